// ---- inc/anl_pkg.sv ----
// Shared constants, register map and types of the negate and logic datapath
package anl_pkg;
    localparam int DATA_W = 32;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_IMM = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_REGSEL = 8'h0C;
    localparam logic [7:0] OFF_REGDATA = 8'h10;
    localparam logic [7:0] OFF_PROGCNT = 8'h14;
    localparam logic [7:0] OFF_LASTLEN = 8'h18;

    // Command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_RD_LSB = 4;
    localparam int CMD_RS_LSB = 8;
    localparam int CMD_FILE_BIT = 12;
    localparam int CMD_FS_LSB = 16;
    localparam int CMD_ALIGN_BIT = 24;

    // Status word fields
    localparam int STAT_FLAGS_LSB = 0;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_DRAIN_BIT = 9;

    // Reset values
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [31:0] PROGCNT_RST = 32'h0000_0000;

    // Machine-state counts
    localparam logic [5:0] SINGLE_STATES = 6'h01;
    localparam logic [5:0] MUL_BASE_STATES = 6'h05;
    localparam logic [5:0] MUL_NEG_EXTRA = 6'h01;
    localparam logic [5:0] DRAIN_MIN_STATES = 6'h02;
    localparam logic [5:0] ORI_ALIGNED_STATES = 6'h02;
    localparam logic [5:0] ORI_UNALIGNED_STATES = 6'h03;

    // Program counter steps in bits
    localparam logic [31:0] PC_STEP_WORD = 32'h0000_0010;
    localparam logic [31:0] PC_STEP_ORI = 32'h0000_0030;

    localparam logic [31:0] MOST_NEG = 32'h8000_0000;
    localparam logic [5:0] FULL_FIELD = 6'h20;

    typedef enum logic [3:0] {
        OP_IDLE = 4'h0,
        OP_TWOS_COMPLEMENT = 4'h1,
        OP_COMPLEMENT_BORROW = 4'h2,
        OP_ONES_COMPLEMENT = 4'h3,
        OP_REG_OR = 4'h4,
        OP_IMMEDIATE_OR = 4'h5,
        OP_UNSIGNED_MULTIPLY = 4'h6,
        OP_WRITE_DRAIN_HOLD = 4'h7
    } anl_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DRAIN = 2'b10
    } anl_state_t;

    typedef struct packed {
        logic n;
        logic c;
        logic z;
        logic v;
    } anl_flags_t;

    typedef struct packed {
        logic immAligned;
        logic [5:0] fieldSize;
        logic fileSel;
        logic [3:0] rs;
        logic [3:0] rd;
        logic [3:0] op;
    } anl_cmd_t;
endpackage : anl_pkg

// ---- core/anl_alu_core.sv ----
// Negate, logic, unsigned multiply and write-drain datapath with Avalon-MM control
`timescale 1ns/1ps
module anl_alu_core (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Avalon-MM slave
    input logic [7:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [3:0] avs_byteenable,
    input logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Memory interface write tracking
    input logic writePending,
    input logic [1:0] writeHiddenStates,
    // Status
    output logic busy,
    output anl_pkg::anl_flags_t flags
);
    logic [31:0] regFile [32];
    anl_pkg::anl_cmd_t cmd_r, newCmd;
    anl_pkg::anl_state_t state_r;
    anl_pkg::anl_flags_t flags_r, newFlags;
    logic [31:0] imm_r, readData_r, readMux, progCnt_r, wrMask, wrWord, newSrc;
    logic [31:0] dVal, sVal, fieldMask, resVal, pairVal;
    logic [5:0] cnt_r, busyLen_r, lastLen_r, startLen;
    logic [4:0] regSel_r, dIdx, sIdx, pairIdx;
    logic waitReq_r, busy_r, doWrite, startOp, commit, drainDone, opDone, resWrite, pairWrite;
    logic [63:0] product;
    logic [32:0] borrowDiff;

    assign avs_readdata = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign busy = busy_r;
    assign flags = flags_r;

    // Byte-lane mask of the current write
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gLane
            assign wrMask[8*g +: 8] = {8{avs_byteenable[g]}};
        end
    endgenerate

    assign wrWord = avs_writedata & wrMask;
    assign doWrite = avs_write && !waitReq_r;
    assign startOp = doWrite && (avs_address == anl_pkg::OFF_CMD);
    assign commit = (state_r == anl_pkg::ST_EXEC) && (cnt_r == 6'h00);
    assign drainDone = (state_r == anl_pkg::ST_DRAIN) && (cnt_r == 6'h00) && !writePending;
    assign opDone = commit || drainDone;

    // Bus answer: one cycle after the request; writes stall while an op runs
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            waitReq_r <= 1'b1;
        else if (!waitReq_r)
            waitReq_r <= 1'b1;
        else if (avs_read || (avs_write && !busy_r))
            waitReq_r <= 1'b0;
    end

    always_comb
    begin
        readMux = 32'h0000_0000;
        unique case (avs_address)
            anl_pkg::OFF_CMD:
            begin
                readMux[anl_pkg::CMD_OP_LSB +: 4] = cmd_r.op;
                readMux[anl_pkg::CMD_RD_LSB +: 4] = cmd_r.rd;
                readMux[anl_pkg::CMD_RS_LSB +: 4] = cmd_r.rs;
                readMux[anl_pkg::CMD_FILE_BIT] = cmd_r.fileSel;
                readMux[anl_pkg::CMD_FS_LSB +: 6] = cmd_r.fieldSize;
                readMux[anl_pkg::CMD_ALIGN_BIT] = cmd_r.immAligned;
            end
            anl_pkg::OFF_IMM: readMux = imm_r;
            anl_pkg::OFF_STATUS:
            begin
                readMux[anl_pkg::STAT_FLAGS_LSB +: 4] = flags_r;
                readMux[anl_pkg::STAT_BUSY_BIT] = busy_r;
                readMux[anl_pkg::STAT_DRAIN_BIT] = (state_r == anl_pkg::ST_DRAIN);
            end
            anl_pkg::OFF_REGSEL: readMux[4:0] = regSel_r;
            anl_pkg::OFF_REGDATA: readMux = regFile[regSel_r];
            anl_pkg::OFF_PROGCNT: readMux = progCnt_r;
            anl_pkg::OFF_LASTLEN: readMux[5:0] = lastLen_r;
            default: readMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            readData_r <= 32'h0000_0000;
        else if (avs_read && waitReq_r)
            readData_r <= readMux;
    end

    // Software-loaded command, immediate and window select
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cmd_r <= '0;
            imm_r <= 32'h0000_0000;
            regSel_r <= 5'h00;
        end
        else if (doWrite)
        begin
            if (startOp)
                cmd_r <= newCmd;
            if (avs_address == anl_pkg::OFF_IMM)
                imm_r <= (imm_r & ~wrMask) | wrWord;
            if (avs_address == anl_pkg::OFF_REGSEL)
                regSel_r <= wrWord[4:0];
        end
    end

    // Decode of a new command and its length in machine states
    always_comb
    begin
        newCmd.op = wrWord[anl_pkg::CMD_OP_LSB +: 4];
        newCmd.rd = wrWord[anl_pkg::CMD_RD_LSB +: 4];
        newCmd.rs = wrWord[anl_pkg::CMD_RS_LSB +: 4];
        newCmd.fileSel = wrWord[anl_pkg::CMD_FILE_BIT];
        newCmd.fieldSize = wrWord[anl_pkg::CMD_FS_LSB +: 6];
        newCmd.immAligned = wrWord[anl_pkg::CMD_ALIGN_BIT];
        newSrc = regFile[{newCmd.fileSel, newCmd.rs}];
        startLen = anl_pkg::SINGLE_STATES;
        if (newCmd.op == anl_pkg::OP_UNSIGNED_MULTIPLY)
            startLen = anl_pkg::MUL_BASE_STATES + {1'b0, newCmd.fieldSize[5:1]}
                + (newSrc[31] ? anl_pkg::MUL_NEG_EXTRA : 6'h00);
        else if (newCmd.op == anl_pkg::OP_IMMEDIATE_OR)
            startLen = newCmd.immAligned ? anl_pkg::ORI_ALIGNED_STATES
                : anl_pkg::ORI_UNALIGNED_STATES;
        else if (newCmd.op == anl_pkg::OP_WRITE_DRAIN_HOLD)
            startLen = ({4'h0, writeHiddenStates} + 6'h01 < anl_pkg::DRAIN_MIN_STATES)
                ? anl_pkg::DRAIN_MIN_STATES : {4'h0, writeHiddenStates} + 6'h01;
    end

    // Sequencer: one clock per machine state
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= anl_pkg::ST_IDLE;
            cnt_r <= 6'h00;
        end
        else
        begin
            unique case (state_r)
                anl_pkg::ST_IDLE:
                    if (startOp)
                    begin
                        cnt_r <= startLen - 6'h01;
                        state_r <= (newCmd.op == anl_pkg::OP_WRITE_DRAIN_HOLD) ? anl_pkg::ST_DRAIN
                            : anl_pkg::ST_EXEC;
                    end
                anl_pkg::ST_EXEC:
                    if (cnt_r == 6'h00)
                        state_r <= anl_pkg::ST_IDLE;
                    else
                        cnt_r <= cnt_r - 6'h01;
                anl_pkg::ST_DRAIN:
                    if (cnt_r != 6'h00)
                        cnt_r <= cnt_r - 6'h01;
                    else if (!writePending)
                        state_r <= anl_pkg::ST_IDLE;
                default: state_r <= anl_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_r <= 1'b0;
            busyLen_r <= 6'h00;
            lastLen_r <= 6'h00;
        end
        else if (startOp)
        begin
            busy_r <= 1'b1;
            busyLen_r <= 6'h01;
        end
        else if (opDone)
        begin
            busy_r <= 1'b0;
            lastLen_r <= busyLen_r;
        end
        else if (busy_r)
            busyLen_r <= busyLen_r + 6'h01;
    end

    // Operands: source and destination always share the selected file
    assign dIdx = {cmd_r.fileSel, cmd_r.rd};
    assign sIdx = {cmd_r.fileSel, cmd_r.rs};
    assign pairIdx = {cmd_r.fileSel, cmd_r.rd + 4'h1};
    assign dVal = regFile[dIdx];
    assign sVal = regFile[sIdx];
    assign fieldMask = (cmd_r.fieldSize >= anl_pkg::FULL_FIELD) ? 32'hFFFF_FFFF
        : (32'h0000_0001 << cmd_r.fieldSize) - 32'h0000_0001;
    assign product = {32'h0000_0000, dVal} * {32'h0000_0000, sVal & fieldMask};
    assign borrowDiff = 33'h0_0000_0000 - {1'b0, dVal} - {32'h0000_0000, flags_r.c};

    always_comb
    begin
        resVal = dVal;
        pairVal = 32'h0000_0000;
        resWrite = 1'b0;
        pairWrite = 1'b0;
        newFlags = flags_r;
        unique case (cmd_r.op)
            anl_pkg::OP_TWOS_COMPLEMENT:
            begin
                resVal = 32'h0000_0000 - dVal;
                resWrite = 1'b1;
                newFlags.n = resVal[31];
                newFlags.z = (resVal == 32'h0000_0000);
                newFlags.c = (dVal != 32'h0000_0000);
                newFlags.v = (dVal == anl_pkg::MOST_NEG);
            end
            anl_pkg::OP_COMPLEMENT_BORROW:
            begin
                resVal = borrowDiff[31:0];
                resWrite = 1'b1;
                newFlags.n = resVal[31];
                newFlags.z = (resVal == 32'h0000_0000);
                newFlags.c = borrowDiff[32];
                newFlags.v = dVal[31] & borrowDiff[31];
            end
            anl_pkg::OP_ONES_COMPLEMENT:
            begin
                resVal = ~dVal;
                resWrite = 1'b1;
                newFlags.z = (resVal == 32'h0000_0000);
            end
            anl_pkg::OP_REG_OR:
            begin
                resVal = sVal | dVal;
                resWrite = 1'b1;
                newFlags.z = (resVal == 32'h0000_0000);
            end
            anl_pkg::OP_IMMEDIATE_OR:
            begin
                resVal = imm_r | dVal;
                resWrite = 1'b1;
                newFlags.z = (resVal == 32'h0000_0000);
            end
            anl_pkg::OP_UNSIGNED_MULTIPLY:
            begin
                resWrite = 1'b1;
                newFlags.z = (product == 64'h0);
                if (!cmd_r.rd[0])
                begin
                    resVal = product[63:32];
                    pairVal = product[31:0];
                    pairWrite = 1'b1;
                end
                else
                    resVal = product[31:0];
            end
            default:
            begin
                resWrite = 1'b0;
            end
        endcase
    end

    // Register files A and B; software window only while idle
    always_ff @(posedge clk)
    begin
        if (commit && resWrite)
            regFile[dIdx] <= resVal;
        if (commit && pairWrite)
            regFile[pairIdx] <= pairVal;
        if (doWrite && (avs_address == anl_pkg::OFF_REGDATA))
            regFile[regSel_r] <= (regFile[regSel_r] & ~wrMask) | wrWord;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            flags_r <= anl_pkg::FLAGS_RST;
        else if (commit)
            flags_r <= newFlags;
        else if (doWrite && (avs_address == anl_pkg::OFF_STATUS) && avs_byteenable[0])
            flags_r <= wrWord[anl_pkg::STAT_FLAGS_LSB +: 4];
    end

    // Program counter in bits; the immediate form is three words long
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            progCnt_r <= anl_pkg::PROGCNT_RST;
        else if (opDone)
            progCnt_r <= progCnt_r + ((cmd_r.op == anl_pkg::OP_IMMEDIATE_OR) ? anl_pkg::PC_STEP_ORI
                : anl_pkg::PC_STEP_WORD);
        else if (doWrite && (avs_address == anl_pkg::OFF_PROGCNT))
            progCnt_r <= (progCnt_r & ~wrMask) | wrWord;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    AST_NEG_RESULT: assert property (commit && cmd_r.op == anl_pkg::OP_TWOS_COMPLEMENT |=>
        regFile[$past(dIdx)] == 32'h0000_0000 - $past(dVal) && flags_r.z == (regFile[$past(dIdx)] == 32'h0))
        else $error("negate result or zero flag wrong");
    AST_NEG_CARRY: assert property (commit && cmd_r.op == anl_pkg::OP_TWOS_COMPLEMENT |=>
        flags_r.c == ($past(dVal) != 32'h0000_0000))
        else $error("negate carry wrong");
    AST_NEG_OVF: assert property (commit && cmd_r.op == anl_pkg::OP_TWOS_COMPLEMENT |=>
        flags_r.v == ($past(dVal) == anl_pkg::MOST_NEG))
        else $error("negate overflow wrong");
    AST_COMPLEMENT_WITH_BORROW_OP_CHAIN: assert property (commit && cmd_r.op == anl_pkg::OP_COMPLEMENT_BORROW |=>
        {flags_r.c, regFile[$past(dIdx)]} == 33'h0_0000_0000 - {1'b0, $past(dVal)} - {32'h0, $past(flags_r.c)})
        else $error("borrow negate chain wrong");
    AST_ONES_KEEP: assert property (commit && cmd_r.op == anl_pkg::OP_ONES_COMPLEMENT |=>
        {flags_r.n, flags_r.c, flags_r.v} == $past({flags_r.n, flags_r.c, flags_r.v}))
        else $error("ones complement touched N, C or V");
    AST_IDLE_KEEP: assert property (startOp && newCmd.op == anl_pkg::OP_IDLE |=> ##1
        $stable(flags_r) && progCnt_r == $past(progCnt_r) + anl_pkg::PC_STEP_WORD)
        else $error("idle op changed status");
    AST_DRAIN_MIN: assert property (startOp && newCmd.op == anl_pkg::OP_WRITE_DRAIN_HOLD |=> busy_r [*2])
        else $error("drain shorter than two states");
    AST_DRAIN_HOLD: assert property (state_r == anl_pkg::ST_DRAIN && writePending |=> busy_r)
        else $error("drain released with write pending");
    AST_DRAIN_FREE: assert property (startOp && newCmd.op == anl_pkg::OP_WRITE_DRAIN_HOLD &&
        writeHiddenStates <= 2'h1 ##1 !writePending [*2] |=> !busy_r && $stable(flags_r))
        else $error("drain added delay or altered flags");
    AST_MUL_LEN: assert property (commit && cmd_r.op == anl_pkg::OP_UNSIGNED_MULTIPLY |->
        busyLen_r == anl_pkg::MUL_BASE_STATES + {1'b0, cmd_r.fieldSize[5:1]} + {5'h00, sVal[31]})
        else $error("multiply length wrong");
    AST_ORI_LEN: assert property (commit && cmd_r.op == anl_pkg::OP_IMMEDIATE_OR |->
        busyLen_r == (cmd_r.immAligned ? anl_pkg::ORI_ALIGNED_STATES : anl_pkg::ORI_UNALIGNED_STATES))
        else $error("immediate OR length wrong");

    COV_NEG_MOSTNEG: cover property (commit && cmd_r.op == anl_pkg::OP_TWOS_COMPLEMENT && dVal == anl_pkg::MOST_NEG);
    COV_DRAIN_PENDING: cover property (state_r == anl_pkg::ST_DRAIN && writePending ##1 drainDone);
    COV_MUL_EVEN: cover property (commit && cmd_r.op == anl_pkg::OP_UNSIGNED_MULTIPLY && !cmd_r.rd[0]);
    COV_ORI_UNALIGNED: cover property (commit && cmd_r.op == anl_pkg::OP_IMMEDIATE_OR && !cmd_r.immAligned);
endmodule : anl_alu_core

// ---- verification/anl_mem_model.sv ----
// Memory-interface stand-in that posts writes and reports them as pending
`timescale 1ns/1ps
module anl_mem_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bench control
    input wire logic postReq,
    input wire logic [7:0] postLen,
    // Pending-write report
    output logic writePending,
    output logic [1:0] writeHiddenStates
);
    logic [7:0] cnt_r;
    logic postReq_r;

    // A new posted write starts on the rising edge of postReq
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_r <= 8'h00;
            postReq_r <= 1'b0;
        end
        else
        begin
            postReq_r <= postReq;
            if (postReq && !postReq_r)
                cnt_r <= postLen;
            else if (cnt_r != 8'h00)
                cnt_r <= cnt_r - 8'h01;
        end
    end

    assign writePending = (cnt_r != 8'h00);
    assign writeHiddenStates = (cnt_r > 8'h03) ? 2'h3 : cnt_r[1:0];
endmodule : anl_mem_model

// ---- verification/anl_alu_core_bench.sv ----
// Self-checking bench of the negate, logic, multiply and drain datapath
`timescale 1ns/1ps
module anl_alu_core_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic writePending;
    logic [1:0] writeHiddenStates;
    logic busy;
    anl_pkg::anl_flags_t flags;
    logic postReq = 1'b0;
    logic [7:0] postLen = 8'h00;
    int error_cnt = 0;
    int checks = 0;
    logic [31:0] rd, pc, st, a, r;
    logic [3:0] op, f, ef;
    // Entry: op, start value, flags before, result, flags after
    logic [75:0] uTab [13] = '{
        {4'h1, 32'h00000000, 4'h0, 32'h00000000, 4'h2}, {4'h1, 32'h55555555, 4'hF, 32'hAAAAAAAB, 4'hC},
        {4'h1, 32'h80000000, 4'h0, 32'h80000000, 4'hD}, {4'h1, 32'hFFFFFFFF, 4'h0, 32'h00000001, 4'h4},
        {4'h2, 32'h00000000, 4'h4, 32'hFFFFFFFF, 4'hC}, {4'h2, 32'h80000000, 4'h0, 32'h80000000, 4'hD},
        {4'h2, 32'h80000000, 4'h4, 32'h7FFFFFFF, 4'h4}, {4'h2, 32'hFFFFFFFF, 4'h4, 32'h00000000, 4'h6},
        {4'h2, 32'h00000000, 4'h0, 32'h00000000, 4'h2}, {4'h3, 32'hFFFFFFFF, 4'hD, 32'h00000000, 4'hF},
        {4'h3, 32'h80000000, 4'hD, 32'h7FFFFFFF, 4'hD}, {4'h0, 32'h12345678, 4'hB, 32'h12345678, 4'hB},
        {4'h9, 32'h12345678, 4'h5, 32'h12345678, 4'h5}};

    always #5 clk = ~clk;

    anl_alu_core i_anl_alu_core (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .writePending(writePending),
        .writeHiddenStates(writeHiddenStates), .busy(busy), .flags(flags));

    anl_mem_model i_anl_mem_model (.clk(clk), .sys_rst(sys_rst), .postReq(postReq), .postLen(postLen),
        .writePending(writePending), .writeHiddenStates(writeHiddenStates));

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flags

    // One Avalon access, released at the edge that completes it
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 300);
        rdat = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 300)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask : bus

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] dummy;
        bus(1'b1, addr, wd, dummy);
    endtask : wr

    task automatic rdr(input logic [7:0] addr, output logic [31:0] d);
        bus(1'b0, addr, 32'h00000000, d);
    endtask : rdr

    task automatic setreg(input logic fl, input logic [3:0] i, input logic [31:0] v);
        wr(anl_pkg::OFF_REGSEL, {27'h0, fl, i});
        wr(anl_pkg::OFF_REGDATA, v);
    endtask : setreg

    task automatic getreg(input logic fl, input logic [3:0] i, output logic [31:0] v);
        wr(anl_pkg::OFF_REGSEL, {27'h0, fl, i});
        rdr(anl_pkg::OFF_REGDATA, v);
    endtask : getreg

    function automatic logic [31:0] mk(input logic [3:0] o, input logic [3:0] d, input logic [3:0] s,
        input logic fl, input logic [5:0] fs, input logic al);
        return {7'h0, al, 2'h0, fs, 3'h0, fl, s, d, o};
    endfunction : mk

    // Issue a command and count the cycles that busy stands high
    task automatic run_op(input logic [31:0] cmd, output logic [31:0] n);
        wr(anl_pkg::OFF_CMD, cmd);
        n = 0;
        @(posedge clk);
        while (busy === 1'b1 && n < 200)
        begin
            n++;
            @(posedge clk);
        end
        if (n >= 200)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask : run_op

    task automatic mul(input logic [3:0] d, input logic [3:0] s, input logic [31:0] dv, input logic [31:0] sv,
        input logic [5:0] fs, input logic [31:0] eD, input logic [31:0] eN, input logic z, input logic [31:0] eSt);
        setreg(1'b0, d + 4'h1, 32'hC3C3C3C3);
        setreg(1'b0, s, sv);
        setreg(1'b0, d, dv);
        wr(anl_pkg::OFF_STATUS, 32'h0000000D);
        run_op(mk(anl_pkg::OP_UNSIGNED_MULTIPLY, d, s, 1'b0, fs, 1'b0), st);
        chk_word(st, eSt);
        chk_flags(flags, {3'b110, 1'b1} | {2'b00, z, 1'b0});
        getreg(1'b0, d, rd);
        chk_word(rd, eD);
        getreg(1'b0, d + 4'h1, rd);
        chk_word(rd, eN);
        getreg(1'b0, s, rd);
        if (d[0])
            chk_word(rd, sv);
    endtask : mul

    task automatic immediate_or_op(input logic al, input logic [31:0] imm, input logic [31:0] v, input logic [31:0] e,
        input logic [3:0] ef2, input logic [31:0] eSt);
        setreg(1'b0, 4'h7, v);
        wr(anl_pkg::OFF_IMM, imm);
        wr(anl_pkg::OFF_STATUS, 32'h0000000D);
        rdr(anl_pkg::OFF_PROGCNT, pc);
        run_op(mk(anl_pkg::OP_IMMEDIATE_OR, 4'h7, 4'h0, 1'b0, 6'h00, al), st);
        chk_word(st, eSt);
        chk_flags(flags, ef2);
        getreg(1'b0, 4'h7, rd);
        chk_word(rd, e);
        rdr(anl_pkg::OFF_PROGCNT, rd);
        chk_word(rd, pc + anl_pkg::PC_STEP_ORI);
        rdr(anl_pkg::OFF_LASTLEN, rd);
        chk_word(rd, eSt);
    endtask : immediate_or_op

    task automatic drain(input logic [7:0] len, input logic [31:0] lo, input logic [31:0] hi);
        wr(anl_pkg::OFF_STATUS, 32'h0000000A);
        postLen <= len;
        postReq <= (len != 8'h00);
        run_op(mk(anl_pkg::OP_WRITE_DRAIN_HOLD, 4'h0, 4'h0, 1'b0, 6'h00, 1'b0), st);
        postReq <= 1'b0;
        chk_word({31'h0, st >= lo && st <= hi}, 32'h1);
        chk_word({31'h0, writePending}, 32'h0);
        chk_flags(flags, 4'hA);
    endtask : drain

    initial
    begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk_word({30'h0, busy, avs_waitrequest}, 32'h1);
        chk_flags(flags, anl_pkg::FLAGS_RST);
        rdr(anl_pkg::OFF_PROGCNT, rd);
        chk_word(rd, anl_pkg::PROGCNT_RST);
        rdr(8'h3C, rd);
        chk_word(rd, 32'h00000000);
        for (int i = 0; i < 13; i++)
        begin
            {op, a, f, r, ef} = uTab[i];
            setreg(1'b0, 4'h3, a);
            wr(anl_pkg::OFF_STATUS, {28'h0, f});
            rdr(anl_pkg::OFF_PROGCNT, pc);
            run_op(mk(op, 4'h3, 4'h0, 1'b0, 6'h00, 1'b0), st);
            chk_word(st, 32'h1);
            chk_flags(flags, ef);
            getreg(1'b0, 4'h3, rd);
            chk_word(rd, r);
            rdr(anl_pkg::OFF_PROGCNT, rd);
            chk_word(rd, pc + anl_pkg::PC_STEP_WORD);
        end
        setreg(1'b0, 4'h2, 32'hFFFFFFFF);
        setreg(1'b1, 4'h2, 32'h00000000);
        setreg(1'b1, 4'h5, 32'h00000000);
        wr(anl_pkg::OFF_STATUS, 32'h0000000D);
        run_op(mk(anl_pkg::OP_REG_OR, 4'h5, 4'h2, 1'b1, 6'h00, 1'b0), st);
        chk_word(st, 32'h1);
        chk_flags(flags, 4'hF);
        getreg(1'b1, 4'h5, rd);
        chk_word(rd, 32'h00000000);
        immediate_or_op(1'b1, 32'h00000000, 32'h00000000, 32'h00000000, 4'hF, 32'h2);
        immediate_or_op(1'b0, 32'hAAAAAAAA, 32'h55555555, 32'hFFFFFFFF, 4'hD, 32'h3);
        mul(4'h0, 4'h1, 32'hFFFF0000, 32'h10001010, 6'h10, 32'h0000100F, 32'hEFF00000, 1'b0, 32'h0D);
        mul(4'h0, 4'h1, 32'hFFFF0000, 32'h10001010, 6'h04, 32'h00000000, 32'h00000000, 1'b1, 32'h07);
        mul(4'h1, 4'h0, 32'h08001056, 32'h0003B074, 6'h20, 32'hDC4486F8, 32'hC3C3C3C3, 1'b0, 32'h15);
        mul(4'h1, 4'h0, 32'h80000000, 32'h00000002, 6'h02, 32'h00000000, 32'hC3C3C3C3, 1'b0, 32'h06);
        mul(4'h2, 4'h4, 32'h00000003, 32'h80000002, 6'h02, 32'h00000000, 32'h00000006, 1'b0, 32'h07);
        drain(8'h00, 32'h2, 32'h2);
        drain(8'h02, 32'h2, 32'h2);
        drain(8'h03, 32'h3, 32'h3);
        drain(8'h0E, 32'hD, 32'hE);
        give_verdict();
    end
endmodule : anl_alu_core_bench
